// file: common/smc_pkg.sv
package smc_pkg;
    // channel counts
    localparam int NUM_IN   = 24;          // input channels
    localparam int NUM_SRC  = NUM_IN + 1;  // inputs plus direct input
    localparam int NUM_BUS  = 16;          // mix bus masters
    localparam int NUM_GRP  = 5;           // mute groups
    localparam int OUT_GRP  = 4;           // index of group five
    localparam int NUM_SYNC = NUM_SRC + NUM_BUS + 2;

    // timing
    localparam int CLK_KHZ       = 250_000;
    localparam int LATCH_MS      = 1000;   // solo latch window
    localparam int DATA_LED_MS   = 50;     // data led flash
    localparam int BAUD_RATE     = 115_200;
    localparam int BAUD_DIV      = (CLK_KHZ * 1000) / BAUD_RATE;
    localparam int TMR_W         = 28;
    localparam int BAUD_W        = 12;
    localparam int FRAME_BITS    = 10;     // start, 8 data, stop

    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CLEAR    = 8'h04;
    localparam logic [7:0] OFF_GRP_IN   = 8'h08;  // five words, one per group
    localparam logic [7:0] OFF_GRP5_OUT = 8'h1C;
    localparam logic [7:0] OFF_SOLO_IN  = 8'h20;
    localparam logic [7:0] OFF_SOLO_OUT = 8'h24;
    localparam logic [7:0] OFF_TRACK    = 8'h28;

    // field positions
    localparam int F_MST_L   = 16;
    localparam int F_MST_R   = 17;
    localparam int F_CLEAR   = 0;

    // tracking message: header in top bits, target code in low bits
    localparam logic [2:0] MSG_HDR  = 3'h5;
    localparam logic [4:0] TGT_MSTL = 5'h10;
    localparam logic [4:0] TGT_MSTR = 5'h11;

    // control register layout, high bits first
    typedef struct packed {
        logic       out_pfl;   // bit 10 output_prefade_force
        logic       in_pfl;    // bit 9 input_prefade_force
        logic       solo_add;  // bit 8
        logic       phones;    // bit 7 headphone mute
        logic       stereo;    // bit 6 stereo monitor mute
        logic       mono;      // bit 5 mono monitor mute
        logic [4:0] grp_on;    // bits 4:0 group masters
    } smc_ctrl_t;
    localparam int CTRL_W = $bits(smc_ctrl_t);

    // monitor mute bundle
    typedef struct packed {
        logic phones;
        logic stereo;
        logic mono;
    } smc_mon_t;

    typedef enum logic [1:0] {
        CLS_NONE,
        CLS_IN,
        CLS_BUS,
        CLS_MST
    } smc_cls_t;
endpackage

// file: src/smc_solo_mute.sv
`timescale 1ns/1ps
// Function
// R1: five groups; group five adds bus masters
// R2: active group master mutes members, lights led
// R3: group mutes hold until master released
// R4: mono and stereo monitor mutes with leds
// R5: headphone mute with status led
// R6: prefade bus output always active, unmuted
// R7: default listen mode is after fade
// R8: without add mode, new solo cancels others
// R9: presses within one second latch together
// R10: add mode keeps all selected solos
// R11: input force puts input solos prefade
// R12: output force puts bus, master solos prefade
// R13: both forces make every solo prefade
// R14: clear led lit while any solo active
// R15: clear-all cancels input and bus solos
// R16: master solos latch, ignore clear-all
// R17: inputs over buses over masters priority
// R18: deselect reverts to next class, own mode
// R19: no solo means listen buses silent
// R20: bus or master press sends serial message
// R21: data led flashes per message
// R22: tracking follows priority and clear-all
// R23: master left/right mutes join group five
// R24: serial byte format chosen, 8N1 framing
module smc_solo_mute import smc_pkg::*; #(
    parameter int LATCH_CYC = LATCH_MS * CLK_KHZ,    // solo latch window
    parameter int LED_CYC   = DATA_LED_MS * CLK_KHZ  // data led flash
) (
    input  wire logic                clk_i,            // 250 MHz clock
    input  wire logic                rst_n_i,          // sync reset
    input  wire logic                psel_i,           // apb select
    input  wire logic                penable_i,        // apb enable
    input  wire logic                pwrite_i,         // apb write
    input  wire logic [7:0]          paddr_i,          // apb address
    input  wire logic [31:0]         pwdata_i,         // apb write data
    output logic      [31:0]         prdata_o,         // apb read data
    output logic                     pready_o,         // apb ready
    output logic                     pslverr_o,        // apb error
    input  wire logic [NUM_SRC-1:0]  src_solo_sw_i,    // input/direct solo keys
    input  wire logic [NUM_BUS-1:0]  bus_solo_sw_i,    // bus master solo keys
    input  wire logic [1:0]          mst_solo_sw_i,    // latching master solos
    output logic      [NUM_IN-1:0]   ch_mute_o,        // channel mutes
    output logic      [NUM_BUS-1:0]  bus_mute_o,       // bus master mutes
    output logic      [1:0]          mst_mute_o,       // master l/r mutes
    output logic      [NUM_GRP-1:0]  grp_led_o,        // group master leds
    output smc_mon_t                 mon_mute_o,       // monitor mutes
    output smc_mon_t                 mon_led_o,        // monitor mute leds
    output logic                     prefade_bus_out_o,// prefade output on
    output logic      [NUM_SRC-1:0]  src_listen_o,     // inputs to listen bus
    output logic      [NUM_BUS-1:0]  bus_listen_o,     // buses to listen bus
    output logic      [1:0]          mst_listen_o,     // masters to listen bus
    output logic                     after_fade_listen_o, // afl bus fed
    output logic                     prefade_listen_o, // pfl bus fed
    output logic      [NUM_SRC-1:0]  src_solo_led_o,   // input solo leds
    output logic      [NUM_BUS-1:0]  bus_solo_led_o,   // bus solo leds
    output logic                     clear_led_o,      // any solo led
    output logic                     data_led_o,       // serial activity
    output logic                     txd_o             // serial to equaliser
);

    // lowest set bit of a bus vector
    function automatic logic [4:0] first_idx(input logic [NUM_BUS-1:0] v);
        logic [4:0] r;
        r = '0;
        for (int i = NUM_BUS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // mapped, word-aligned offset
    function automatic logic word_hit(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_TRACK);
    endfunction

    smc_ctrl_t              ctrl;
    logic [NUM_IN-1:0]      grp_in [NUM_GRP];
    logic [NUM_BUS+1:0]     grp5_out;
    logic [NUM_SYNC-1:0]    sync1, sync2, sync3;
    logic [NUM_SRC-1:0]     solo_src, next_solo_src;
    logic [NUM_BUS-1:0]     solo_bus, next_solo_bus;
    logic [1:0]             mst;
    logic [TMR_W-1:0]       win_tmr;
    logic                   clear_pulse;
    smc_cls_t               cls;
    logic [4:0]             tgt, next_tgt;
    logic                   tgt_ok, next_tgt_ok;
    logic                   send;
    logic [7:0]             pend_byte;
    logic                   pend;
    logic [FRAME_BITS-1:0]  shift;
    logic [3:0]             bits_left;
    logic [BAUD_W-1:0]      baud_cnt;
    logic [TMR_W-1:0]       led_tmr;
    logic                   wr, setup, hit;
    logic [NUM_SRC-1:0]     src_press;
    logic [NUM_BUS-1:0]     bus_press;
    logic [1:0]             mst_on;

    // apb strobes
    assign setup    = psel_i && !penable_i;
    assign hit      = word_hit(paddr_i);
    assign wr       = psel_i && penable_i && pwrite_i && hit;
    assign pready_o = 1'b1;

    // front panel keys, two-stage sync then edge stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= {mst_solo_sw_i, bus_solo_sw_i, src_solo_sw_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // rising edges of the synced keys
    assign src_press = sync2[NUM_SRC-1:0] & ~sync3[NUM_SRC-1:0];
    assign bus_press = sync2[NUM_SRC+NUM_BUS-1:NUM_SRC]
                     & ~sync3[NUM_SRC+NUM_BUS-1:NUM_SRC];
    assign mst       = sync2[NUM_SYNC-1:NUM_SYNC-2];      // see R16
    assign mst_on    = mst & ~sync3[NUM_SYNC-1:NUM_SYNC-2];

    // control and mute assignment registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl     <= '0;
            grp5_out <= '0;
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_in[g] <= '0;
            end
        end else if (wr) begin
            if (paddr_i == OFF_CTRL) begin
                ctrl <= smc_ctrl_t'(pwdata_i[CTRL_W-1:0]);
            end
            if (paddr_i == OFF_GRP5_OUT) begin
                grp5_out <= pwdata_i[NUM_BUS+1:0];          // see R23
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                if (paddr_i == OFF_GRP_IN + 8'(4 * g)) begin
                    grp_in[g] <= pwdata_i[NUM_IN-1:0];      // see R1
                end
            end
        end
    end

    // clear-all strobe from a write of one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clear_pulse <= 1'b0;
        end else begin
            clear_pulse <= wr && (paddr_i == OFF_CLEAR) && pwdata_i[F_CLEAR];
        end
    end

    // read data and error caught in the setup cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
        end else if (setup) begin
            pslverr_o <= !hit;
            prdata_o  <= '0;
            case (paddr_i)
                OFF_CTRL:     prdata_o <= 32'(ctrl);
                OFF_GRP5_OUT: prdata_o <= 32'(grp5_out);
                OFF_SOLO_IN:  prdata_o <= 32'(solo_src);
                OFF_SOLO_OUT: prdata_o <= {10'h000, 2'(cls), 2'b00,
                                           mst, solo_bus};
                OFF_TRACK:    prdata_o <= {26'h000_0000, tgt_ok, tgt};
                default: begin
                    for (int g = 0; g < NUM_GRP; g++) begin
                        if (paddr_i == OFF_GRP_IN + 8'(4 * g)) begin
                            prdata_o <= 32'(grp_in[g]);
                        end
                    end
                end
            endcase
        end
    end

    // group and monitor mutes, leds follow the mute state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ch_mute_o         <= '0;
            bus_mute_o        <= '0;
            mst_mute_o        <= '0;
            grp_led_o         <= '0;
            mon_mute_o        <= '0;
            mon_led_o         <= '0;
            prefade_bus_out_o <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                ch_mute_o[i] <= 1'b0;
                for (int g = 0; g < NUM_GRP; g++) begin
                    if (ctrl.grp_on[g] && grp_in[g][i]) begin
                        ch_mute_o[i] <= 1'b1;               // see R2, R3
                    end
                end
            end
            bus_mute_o <= ctrl.grp_on[OUT_GRP] ? grp5_out[NUM_BUS-1:0] : '0;
            mst_mute_o <= ctrl.grp_on[OUT_GRP]                       // see R23
                        ? {grp5_out[F_MST_R], grp5_out[F_MST_L]} : 2'b00;
            grp_led_o  <= ctrl.grp_on;                                // see R2
            mon_mute_o <= '{ctrl.phones, ctrl.stereo, ctrl.mono};     // see R4, R5
            mon_led_o  <= '{ctrl.phones, ctrl.stereo, ctrl.mono};
            prefade_bus_out_o <= 1'b1;                                // see R6
        end
    end

    // latch window restarts on every input or bus solo press
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            win_tmr <= '0;
        end else if ((|src_press) || (|bus_press)) begin
            win_tmr <= TMR_W'(LATCH_CYC - 1);                         // see R9
        end else if (win_tmr != '0) begin
            win_tmr <= win_tmr - 1'b1;
        end
    end

    // solo selection: toggle, intercancel, latch, add, clear
    always_comb begin
        logic keep;
        keep          = ctrl.solo_add || (win_tmr != '0);             // see R9, R10
        next_solo_src = keep ? solo_src : (solo_src & src_press);     // see R8
        next_solo_bus = keep ? solo_bus : (solo_bus & bus_press);
        if (!(|src_press) && !(|bus_press)) begin
            next_solo_src = solo_src;
            next_solo_bus = solo_bus;
        end
        next_solo_src = next_solo_src ^ src_press;
        next_solo_bus = next_solo_bus ^ bus_press;
        if (clear_pulse) begin
            next_solo_src = '0;                                       // see R15
            next_solo_bus = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            solo_src <= '0;
            solo_bus <= '0;
        end else begin
            solo_src <= next_solo_src;
            solo_bus <= next_solo_bus;
        end
    end

    // highest active class decides what is heard
    always_comb begin
        if (|solo_src) begin
            cls = CLS_IN;                                             // see R17
        end else if (|solo_bus) begin
            cls = CLS_BUS;                                            // see R18
        end else if (|mst) begin
            cls = CLS_MST;
        end else begin
            cls = CLS_NONE;
        end
    end

    // listen routing and bus mode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            src_listen_o        <= '0;
            bus_listen_o        <= '0;
            mst_listen_o        <= '0;
            after_fade_listen_o <= 1'b0;
            prefade_listen_o    <= 1'b0;
            src_solo_led_o      <= '0;
            bus_solo_led_o      <= '0;
            clear_led_o         <= 1'b0;
        end else begin
            src_listen_o   <= (cls == CLS_IN)  ? solo_src : '0;
            bus_listen_o   <= (cls == CLS_BUS) ? solo_bus : '0;
            mst_listen_o   <= (cls == CLS_MST) ? mst : 2'b00;
            src_solo_led_o <= solo_src;
            bus_solo_led_o <= solo_bus;
            clear_led_o    <= (|solo_src) || (|solo_bus) || (|mst);   // see R14
            case (cls)
                CLS_IN: begin
                    prefade_listen_o    <= ctrl.in_pfl;               // see R11, R13
                    after_fade_listen_o <= !ctrl.in_pfl;              // see R7
                end
                CLS_BUS, CLS_MST: begin
                    prefade_listen_o    <= ctrl.out_pfl;              // see R12
                    after_fade_listen_o <= !ctrl.out_pfl;
                end
                default: begin
                    prefade_listen_o    <= 1'b0;                      // see R19
                    after_fade_listen_o <= 1'b0;
                end
            endcase
        end
    end

    // equaliser tracking target from bus and master solos
    always_comb begin
        logic [NUM_BUS-1:0] new_bus;
        new_bus     = bus_press & next_solo_bus;
        next_tgt    = tgt;
        next_tgt_ok = 1'b0;
        if (|new_bus) begin
            next_tgt    = first_idx(new_bus);                         // see R20
            next_tgt_ok = 1'b1;
        end else if (|next_solo_bus) begin
            next_tgt_ok = 1'b1;                                       // see R22
            if (!(tgt_ok && tgt < TGT_MSTL && next_solo_bus[tgt[3:0]])) begin
                next_tgt = first_idx(next_solo_bus);
            end
        end else if (|mst) begin
            next_tgt    = mst[0] ? TGT_MSTL : TGT_MSTR;               // see R22
            next_tgt_ok = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tgt    <= '0;
            tgt_ok <= 1'b0;
            send   <= 1'b0;
        end else begin
            tgt    <= next_tgt;
            tgt_ok <= next_tgt_ok;
            send   <= next_tgt_ok && ((next_tgt != tgt) || !tgt_ok
                      || (|(bus_press & next_solo_bus))
                      || ((|mst_on) && !(|next_solo_bus)));           // see R20
        end
    end

    // serial sender, 8N1, one message held while busy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend      <= 1'b0;
            pend_byte <= '0;
            shift     <= '1;
            bits_left <= '0;
            baud_cnt  <= '0;
        end else begin
            if (send) begin
                pend      <= 1'b1;                                    // see R24
                pend_byte <= {MSG_HDR, tgt};
            end
            if (bits_left != '0) begin
                if (baud_cnt == BAUD_W'(BAUD_DIV - 1)) begin
                    baud_cnt  <= '0;
                    shift     <= {1'b1, shift[FRAME_BITS-1:1]};
                    bits_left <= bits_left - 1'b1;
                end else begin
                    baud_cnt <= baud_cnt + 1'b1;
                end
            end else if (pend && !send) begin
                pend      <= 1'b0;
                shift     <= {1'b1, pend_byte, 1'b0};
                bits_left <= 4'(FRAME_BITS);
                baud_cnt  <= '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            txd_o <= 1'b1;
        end else begin
            txd_o <= (bits_left != '0) ? shift[0] : 1'b1;
        end
    end

    // data led flash on each message
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            led_tmr    <= '0;
            data_led_o <= 1'b0;
        end else begin
            if (send) begin
                led_tmr <= TMR_W'(LED_CYC - 1);                       // see R21
            end else if (led_tmr != '0) begin
                led_tmr <= led_tmr - 1'b1;
            end
            data_led_o <= send || (led_tmr != '0);
        end
    end

endmodule // smc_solo_mute

// file: testbench/smc_checker.sv
`timescale 1ns/1ps
module smc_checker import smc_pkg::*; (
    input logic               clk_i, // clock
    input logic               rst_n_i, // sync reset
    input logic [NUM_IN-1:0]  ch_mute_o, // channel mutes
    input logic [NUM_BUS-1:0] bus_mute_o, // bus mutes
    input logic [1:0]         mst_mute_o, // master mutes
    input logic [NUM_GRP-1:0] grp_led_o, // group leds
    input smc_mon_t           mon_mute_o, // monitor mutes
    input smc_mon_t           mon_led_o, // monitor leds
    input logic               prefade_bus_out_o, // prefade output
    input logic [NUM_SRC-1:0] src_listen_o, // input listen
    input logic [NUM_BUS-1:0] bus_listen_o, // bus listen
    input logic [1:0]         mst_listen_o, // master listen
    input logic               after_fade_listen_o, // afl fed
    input logic               prefade_listen_o, // pfl fed
    input logic [NUM_SRC-1:0] src_solo_led_o, // input solo leds
    input logic [NUM_BUS-1:0] bus_solo_led_o, // bus solo leds
    input logic               clear_led_o, // any solo
    input logic               data_led_o, // serial activity
    input logic               txd_o // serial line
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // frame start and its held start bit
    sequence s_start;
        $fell(txd_o);
    endsequence
    sequence s_low;
        !txd_o [*8];
    endsequence
    // two idle cycles with no solo
    sequence s_idle;
        !clear_led_o ##1 !clear_led_o;
    endsequence

    chk_prefade_on: assert property ($past(rst_n_i) |-> prefade_bus_out_o)
        else $error("prefade output not active");
    chk_mon_leds: assert property (mon_led_o == mon_mute_o)
        else $error("monitor led differs from mute");
    chk_grp5_outs: assert property ((|bus_mute_o || |mst_mute_o) |-> grp_led_o[OUT_GRP])
        else $error("output muted without group five");
    chk_grp_mutes: assert property (|ch_mute_o |-> |grp_led_o)
        else $error("channel muted without group master");
    chk_clear_led: assert property ((|src_solo_led_o || |bus_solo_led_o) |-> clear_led_o)
        else $error("clear led dark with solo active");
    chk_one_class: assert property ($onehot0({|src_listen_o, |bus_listen_o, |mst_listen_o}))
        else $error("two solo classes heard");
    chk_one_mode: assert property (!(after_fade_listen_o && prefade_listen_o))
        else $error("both listen buses fed");
    chk_quiet_idle: assert property (s_idle |-> !after_fade_listen_o && !prefade_listen_o)
        else $error("listen bus fed with no solo");
    chk_start_bit: assert property (s_start |=> s_low)
        else $error("start bit too short");
    chk_data_led: assert property ($rose(data_led_o) |=> data_led_o [*8])
        else $error("data led flash too short");
endmodule // smc_checker

// file: testbench/smc_eq_rx.sv
`timescale 1ns/1ps
// equaliser receiver model, 8n1 at the console baud rate
module smc_eq_rx import smc_pkg::*; (
    input  wire logic  clk_i,  // system clock
    input  wire logic  rxd_i,  // line from console
    output logic [7:0] byte_o, // last received byte
    output logic       stb_o   // pulse per byte
);
    int         cnt  = 0;
    int         nbit = 0;
    logic       busy = 1'b0;
    logic [9:0] sh   = '0;

    // mid-bit sampler, byte strobed only with good start and stop
    always @(posedge clk_i) begin
        stb_o <= 1'b0;
        if (!busy) begin
            if (rxd_i === 1'b0) begin
                busy <= 1'b1;
                cnt  <= BAUD_DIV / 2;
                nbit <= 0;
            end
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else begin
            sh   <= {rxd_i, sh[9:1]};
            cnt  <= BAUD_DIV - 1;
            nbit <= nbit + 1;
            if (nbit == FRAME_BITS - 1) begin
                busy   <= 1'b0;
                stb_o  <= (rxd_i === 1'b1) && (sh[1] === 1'b0);
                byte_o <= sh[9:2];
            end
        end
    end
endmodule // smc_eq_rx

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import smc_pkg::*; ;
    localparam int LATCH = 200;
    localparam int LED   = 20;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [49:0] exp; // ch, bus, master, group led, monitor
    } smc_row_t;
    logic               clk_i, rst_n_i, psel, pen, pwr, pready, pslverr, rerr;
    logic [7:0]         paddr, rx_byte;
    logic [31:0]        pwdata, prdata, rd;
    logic [NUM_SRC-1:0] src_sw, src_led, src_lis;
    logic [NUM_BUS-1:0] bus_sw, bus_led, bus_lis, bus_mute;
    logic [1:0]         mst_sw, mst_lis, mst_mute;
    logic [NUM_IN-1:0]  ch_mute;
    logic [NUM_GRP-1:0] grp_led;
    smc_mon_t           mon_mute, mon_led;
    logic               pfo, after_fade_listen, prefade_listen, clr_led, dat_led, txd, rx_stb;
    int                 err_count, num_checks;
    smc_row_t           rows [6];

    smc_solo_mute #(.LATCH_CYC(LATCH), .LED_CYC(LED)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .src_solo_sw_i(src_sw), .bus_solo_sw_i(bus_sw), .mst_solo_sw_i(mst_sw), .ch_mute_o(ch_mute),
        .bus_mute_o(bus_mute), .mst_mute_o(mst_mute), .grp_led_o(grp_led), .mon_mute_o(mon_mute),
        .mon_led_o(mon_led), .prefade_bus_out_o(pfo), .src_listen_o(src_lis), .bus_listen_o(bus_lis),
        .mst_listen_o(mst_lis), .after_fade_listen_o(after_fade_listen), .prefade_listen_o(prefade_listen),
        .src_solo_led_o(src_led), .bus_solo_led_o(bus_led), .clear_led_o(clr_led),
        .data_led_o(dat_led), .txd_o(txd));
    smc_eq_rx i_eq (.clk_i(clk_i), .rxd_i(txd), .byte_o(rx_byte), .stb_o(rx_stb));

    // 250 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic lim(input int n, input int m);
        if (n >= m) begin
            err_count++;
            $display("timeout t=%0t", $time);
            test_done();
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd   = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        lim(n, 50);
        @(posedge clk_i);
    endtask
    // momentary key press
    task automatic press(input logic [NUM_SRC-1:0] s, input logic [NUM_BUS-1:0] b);
        src_sw <= s;
        bus_sw <= b;
        repeat (4) @(posedge clk_i);
        src_sw <= '0;
        bus_sw <= '0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic rx(input logic [7:0] e);
        int n;
        n = 0;
        while (rx_stb !== 1'b1 && n < 30000) begin
            @(posedge clk_i);
            n++;
        end
        lim(n, 30000);
        chk(rx_byte, e);
    endtask
    task automatic ctrl(input logic [31:0] d);
        apb(1'b1, OFF_CTRL, d);
        repeat (3) @(posedge clk_i);
    endtask

    initial begin
        rows = '{'{16'h0001, {24'h00_0001, 16'h0000, 2'b00, 5'h01, 3'h0}},
                 '{16'h000E, {24'h00_000E, 16'h0000, 2'b00, 5'h0E, 3'h0}},
                 '{16'h0010, {24'h00_0010, 16'h0008, 2'b01, 5'h10, 3'h0}},
                 '{16'h00E0, {24'h00_0000, 16'h0000, 2'b00, 5'h00, 3'h7}},
                 '{16'h0045, {24'h00_0005, 16'h0000, 2'b00, 5'h05, 3'h2}},
                 '{16'h0000, {24'h00_0000, 16'h0000, 2'b00, 5'h00, 3'h0}}};
        {err_count, num_checks} = '0;
        {rst_n_i, psel, pen, pwr, paddr, pwdata, src_sw, bus_sw, mst_sw} = '0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({txd, pfo, clr_led, after_fade_listen, prefade_listen, grp_led}, 10'h300);
        $display("reset done");
        // group g+1 holds channel g, group five also bus 3 and master left
        for (int g = 0; g < NUM_GRP; g++) begin
            apb(1'b1, OFF_GRP_IN + 8'(4 * g), 32'(1 << g));
        end
        apb(1'b1, OFF_GRP5_OUT, 32'h0001_0008);
        foreach (rows[i]) begin
            ctrl({16'h0000, rows[i].ctrl});
            chk({ch_mute, bus_mute, mst_mute, grp_led, mon_mute}, rows[i].exp);
        end
        apb(1'b0, OFF_GRP5_OUT, '0);
        chk(rd, 32'h0001_0008);
        $display("mute table done");
        apb(1'b1, 8'h40, 32'h0000_001F);
        repeat (2) @(posedge clk_i);
        chk({rerr, grp_led}, 6'h20);
        press(25'h000_0001, '0);
        repeat (LATCH + 10) @(posedge clk_i);
        press(25'h000_0002, '0);
        chk(src_led, 25'h000_0002);
        repeat (LATCH + 10) @(posedge clk_i);
        press(25'h000_0004, '0);
        press(25'h000_0008, '0);
        chk({src_led, src_lis, after_fade_listen, prefade_listen}, {25'h000_000C, 25'h000_000C, 2'b10});
        ctrl(32'h0000_0200);
        chk({after_fade_listen, prefade_listen}, 2'b01);
        ctrl(32'h0000_0500);
        chk({after_fade_listen, prefade_listen}, 2'b10);
        $display("input solo done");
        press('0, 16'h0020);
        chk({bus_led, src_led, |bus_lis}, {16'h0020, 25'h000_000C, 1'b0});
        rx(8'hA5);
        press(25'h000_000C, '0);
        chk({bus_lis, after_fade_listen, prefade_listen}, {16'h0020, 2'b01});
        mst_sw <= 2'b01;
        repeat (8) @(posedge clk_i);
        apb(1'b1, OFF_CLEAR, 32'h0000_0001);
        repeat (4) @(posedge clk_i);
        chk({bus_led, src_led, clr_led, mst_lis}, {41'h0, 1'b1, 2'b01});
        rx(8'hB0);
        $display("tracking done");
        ctrl(32'h0000_0600);
        press(25'h000_0001, '0);
        chk({src_lis, after_fade_listen, prefade_listen}, {25'h000_0001, 2'b01});
        press(25'h000_0001, '0);
        mst_sw <= 2'b00;
        repeat (8) @(posedge clk_i);
        chk({clr_led, after_fade_listen, prefade_listen, mst_lis, src_lis}, 30'h0);
        $display("idle done");
        test_done();
    end
endmodule // tb_top

bind smc_solo_mute smc_checker i_chk (.*);
